// file: hdl/cfgar_pkg.sv
package cfgar_pkg;

  // ==========================================================================
  // I/O port offsets and access shape
  // ==========================================================================
  localparam logic [15:0] CFGAR_ADDR_PORT_OFS = 16'h0CF8;
  localparam logic [15:0] CFGAR_DATA_PORT_OFS = 16'h0CFC;
  localparam logic [3:0]  CFGAR_BE_DWORD      = 4'hF;

  // ==========================================================================
  // Address port fields and reset value
  // ==========================================================================
  localparam int          CFGAR_EN_BIT        = 31;
  localparam int          CFGAR_RSVD_HI       = 30;
  localparam int          CFGAR_RSVD_LO       = 24;
  localparam int          CFGAR_BUS_HI        = 23;
  localparam int          CFGAR_BUS_LO        = 16;
  localparam int          CFGAR_DEV_HI        = 15;
  localparam int          CFGAR_DEV_LO        = 11;
  localparam int          CFGAR_FUNC_HI       = 10;
  localparam int          CFGAR_FUNC_LO       = 8;
  localparam int          CFGAR_REG_HI        = 7;
  localparam int          CFGAR_REG_LO        = 2;
  localparam logic [31:0] CFGAR_ADDR_PORT_RST = 32'h0000_0000;
  localparam logic [31:0] CFGAR_ADDR_WMASK    = 32'h80FF_FFFC;

  // ==========================================================================
  // Bus zero device numbers and bridge constants
  // ==========================================================================
  localparam logic [4:0]  CFGAR_DEV_HUB_BRIDGE = 5'h00;
  localparam logic [4:0]  CFGAR_DEV_GFX_BRIDGE = 5'h01;
  localparam logic [7:0]  CFGAR_BUS_ZERO       = 8'h00;
  localparam logic [7:0]  CFGAR_PRI_BUS        = 8'h00;
  localparam logic [1:0]  CFGAR_TYPE0_CODE     = 2'h0;
  localparam logic [1:0]  CFGAR_TYPE1_CODE     = 2'h1;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {CFGAR_CYC_IO, CFGAR_CYC_CFG0, CFGAR_CYC_CFG1} cfgar_cyc_t;
  typedef enum logic [1:0] {CFGAR_RT_LOCAL, CFGAR_RT_INT, CFGAR_RT_HUB, CFGAR_RT_GFX} cfgar_route_t;
  typedef enum logic {CFGAR_ST_IDLE, CFGAR_ST_WAIT} cfgar_state_t;

  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfgar_io_t;

  typedef struct packed {
    cfgar_cyc_t  kind;
    logic        wr;
    logic [3:0]  be;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cfgar_req_t;

endpackage : cfgar_pkg

// file: hdl/cfgar_router.sv
// Functional notes
// - Only address/data port access method supported
// - Address port 0CF8h-0CFBh, data port 0CFCh-0CFFh
// - Config cycles only when enable bit set
// - Data port access with enable bit clear passes to hub as I/O
// - Eight functions, 256 byte registers decoded
// - Decode bus 23:16 and device; zero bus zero
// - Device 0 hub bridge, device 1 graphics
// - Enabled internal hits stay off hub link
// - Disabled internal device goes hub Type 0
// - Bus outside graphics range: hub Type 1
// - Bus equals secondary: graphics Type 0
// - Above secondary up to subordinate: graphics Type 1
// - Primary bus number reads fixed zero
// - Byte/word address port access passes as I/O
// - Address bits 30:24 read zero, ignore writes
module cfgar_router
  import cfgar_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_io_valid,
  input  wire cfgar_io_t  i_io,
  output logic            o_io_ready,
  output logic            o_io_ack,
  output logic [31:0]     o_io_rdata,
  input  wire logic       i_dev0_en,
  input  wire logic       i_dev1_en,
  input  wire logic [7:0] i_sec_bus,
  input  wire logic [7:0] i_sub_bus,
  output logic [7:0]      o_pri_bus,
  output cfgar_req_t      o_down,
  output logic            o_int_valid,
  input  wire logic       i_int_ack,
  input  wire logic [31:0] i_int_rdata,
  output logic            o_hub_valid,
  input  wire logic       i_hub_ack,
  input  wire logic [31:0] i_hub_rdata,
  output logic            o_gfx_valid,
  input  wire logic       i_gfx_ack,
  input  wire logic [31:0] i_gfx_rdata
);

  // ==========================================================================
  // Decode helpers
  // ==========================================================================
  function automatic logic port_hit(input logic [15:0] addr, input logic [15:0] ofs);
    port_hit = (addr[15:2] == ofs[15:2]);
  endfunction : port_hit

  function automatic cfgar_route_t cfg_route(input logic [7:0] bus, input logic [4:0] dev,
                                             input logic en0, input logic en1,
                                             input logic [7:0] sec, input logic [7:0] sub);
    if (bus == CFGAR_BUS_ZERO) begin
      if ((dev == CFGAR_DEV_HUB_BRIDGE && en0) || (dev == CFGAR_DEV_GFX_BRIDGE && en1)) begin
        cfg_route = CFGAR_RT_INT;
      end else begin
        cfg_route = CFGAR_RT_HUB;
      end
    end else if (bus >= sec && bus <= sub) begin
      cfg_route = CFGAR_RT_GFX;
    end else begin
      cfg_route = CFGAR_RT_HUB;
    end
  endfunction : cfg_route

  // ==========================================================================
  // State
  // ==========================================================================
  cfgar_state_t  state_reg;
  cfgar_route_t  route_reg;
  cfgar_req_t    down_reg;
  logic [31:0]   addr_port_reg;
  logic          ack_reg;
  logic [31:0]   rdata_reg;

  // ==========================================================================
  // Request decode
  // ==========================================================================
  wire logic          take      = i_io_valid && (state_reg == CFGAR_ST_IDLE);
  wire logic          hit_addr  = port_hit(i_io.addr, CFGAR_ADDR_PORT_OFS);
  wire logic          hit_data  = port_hit(i_io.addr, CFGAR_DATA_PORT_OFS);
  wire logic          addr_dw   = hit_addr && (i_io.be == CFGAR_BE_DWORD);
  wire logic          cfg_en    = addr_port_reg[CFGAR_EN_BIT];
  wire logic [7:0]    cur_bus   = addr_port_reg[CFGAR_BUS_HI:CFGAR_BUS_LO];
  wire logic [4:0]    cur_dev   = addr_port_reg[CFGAR_DEV_HI:CFGAR_DEV_LO];
  wire logic          is_cfg    = hit_data && cfg_en;
  wire cfgar_route_t  cfg_rt    = cfg_route(cur_bus, cur_dev, i_dev0_en, i_dev1_en,
                                            i_sec_bus, i_sub_bus);
  wire cfgar_route_t  req_rt    = addr_dw ? CFGAR_RT_LOCAL : (is_cfg ? cfg_rt : CFGAR_RT_HUB);
  wire logic          cfg_t1    = (cur_bus != CFGAR_BUS_ZERO) && (cur_bus != i_sec_bus);
  wire cfgar_cyc_t    req_kind  = !is_cfg ? CFGAR_CYC_IO :
                                  (cfg_t1 ? CFGAR_CYC_CFG1 : CFGAR_CYC_CFG0);
  wire logic [1:0]    type_code = cfg_t1 ? CFGAR_TYPE1_CODE : CFGAR_TYPE0_CODE;
  wire logic [31:0]   cfg_addr  = {addr_port_reg[31:CFGAR_REG_LO], type_code};
  wire cfgar_req_t    req       = '{kind:  req_kind,
                                    wr:    i_io.wr,
                                    be:    i_io.be,
                                    addr:  is_cfg ? cfg_addr : {16'h0000, i_io.addr},
                                    wdata: i_io.wdata};
  wire logic          sel_ack   = (route_reg == CFGAR_RT_INT) ? i_int_ack :
                                  (route_reg == CFGAR_RT_GFX) ? i_gfx_ack : i_hub_ack;
  wire logic [31:0]   sel_rdata = (route_reg == CFGAR_RT_INT) ? i_int_rdata :
                                  (route_reg == CFGAR_RT_GFX) ? i_gfx_rdata : i_hub_rdata;
  wire logic          waiting   = (state_reg == CFGAR_ST_WAIT);

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg     <= CFGAR_ST_IDLE;
      route_reg     <= CFGAR_RT_LOCAL;
      down_reg      <= '0;
      addr_port_reg <= CFGAR_ADDR_PORT_RST;
      ack_reg       <= 1'b0;
      rdata_reg     <= 32'h0000_0000;
    end else begin
      ack_reg <= 1'b0;
      case (state_reg)
        CFGAR_ST_IDLE: begin
          if (take && req_rt == CFGAR_RT_LOCAL) begin
            if (i_io.wr) begin
              addr_port_reg <= i_io.wdata & CFGAR_ADDR_WMASK;
            end
            rdata_reg <= addr_port_reg;
            ack_reg   <= 1'b1;
          end else if (take) begin
            down_reg  <= req;
            route_reg <= req_rt;
            state_reg <= CFGAR_ST_WAIT;
          end
        end
        CFGAR_ST_WAIT: begin
          if (sel_ack) begin
            rdata_reg <= sel_rdata;
            ack_reg   <= 1'b1;
            state_reg <= CFGAR_ST_IDLE;
          end
        end
        default: begin
          state_reg <= CFGAR_ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign o_io_ready  = (state_reg == CFGAR_ST_IDLE);
  assign o_io_ack    = ack_reg;
  assign o_io_rdata  = rdata_reg;
  assign o_pri_bus   = CFGAR_PRI_BUS;
  assign o_down      = down_reg;
  assign o_int_valid = waiting && (route_reg == CFGAR_RT_INT);
  assign o_hub_valid = waiting && (route_reg == CFGAR_RT_HUB);
  assign o_gfx_valid = waiting && (route_reg == CFGAR_RT_GFX);

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  chk_local_dword: assert property (take && addr_dw |=> o_io_ack && o_io_ready)
    else $error("dword address port access not answered locally");
  chk_addr_load: assert property (take && addr_dw && i_io.wr |=>
                                  addr_port_reg == ($past(i_io.wdata) & CFGAR_ADDR_WMASK))
    else $error("address port did not load written value");
  chk_rsvd_zero: assert property (addr_port_reg[CFGAR_RSVD_HI:CFGAR_RSVD_LO] == 7'h00)
    else $error("reserved address bits not zero");
  chk_partial_pass: assert property (take && hit_addr && !addr_dw |=> o_hub_valid &&
                                     o_down.kind == CFGAR_CYC_IO && $stable(addr_port_reg))
    else $error("partial address port access not passed as I/O");
  chk_disabled_io: assert property (take && hit_data && !cfg_en |=>
                                    o_hub_valid && o_down.kind == CFGAR_CYC_IO)
    else $error("data port access converted while disabled");
  chk_internal_hit: assert property (take && is_cfg && cur_bus == CFGAR_BUS_ZERO &&
                                     cur_dev == CFGAR_DEV_HUB_BRIDGE && i_dev0_en |=>
                                     o_int_valid && !o_hub_valid && !o_gfx_valid)
    else $error("device 0 hit not kept internal");
  chk_dev1_internal: assert property (take && is_cfg && cur_bus == CFGAR_BUS_ZERO &&
                                      cur_dev == CFGAR_DEV_GFX_BRIDGE && i_dev1_en |=>
                                      o_int_valid && !o_hub_valid && o_down.kind == CFGAR_CYC_CFG0)
    else $error("device 1 hit not kept internal");
  chk_disabled_fwd: assert property (take && is_cfg && cur_bus == CFGAR_BUS_ZERO &&
                                     cur_dev == CFGAR_DEV_GFX_BRIDGE && !i_dev1_en |=>
                                     o_hub_valid && o_down.kind == CFGAR_CYC_CFG0)
    else $error("disabled device not forwarded as type 0");
  chk_dev0_fwd: assert property (take && is_cfg && cur_bus == CFGAR_BUS_ZERO &&
                                 cur_dev == CFGAR_DEV_HUB_BRIDGE && !i_dev0_en |=>
                                 o_hub_valid && !o_int_valid && o_down.kind == CFGAR_CYC_CFG0)
    else $error("disabled device 0 not forwarded as type 0");
  chk_hub_type1: assert property (take && is_cfg && cur_bus != CFGAR_BUS_ZERO &&
                                  (cur_bus < i_sec_bus || cur_bus > i_sub_bus) |=>
                                  o_hub_valid && o_down.kind == CFGAR_CYC_CFG1 &&
                                  o_down.addr[1:0] == CFGAR_TYPE1_CODE)
    else $error("out of range bus not sent hub type 1");
  chk_gfx_type0: assert property (take && is_cfg && cur_bus != CFGAR_BUS_ZERO &&
                                  cur_bus == i_sec_bus && cur_bus <= i_sub_bus |=>
                                  o_gfx_valid && o_down.kind == CFGAR_CYC_CFG0)
    else $error("secondary bus not sent graphics type 0");
  chk_gfx_type1: assert property (take && is_cfg && cur_bus != CFGAR_BUS_ZERO &&
                                  cur_bus > i_sec_bus && cur_bus <= i_sub_bus |=>
                                  o_gfx_valid && o_down.kind == CFGAR_CYC_CFG1)
    else $error("subordinate range not sent graphics type 1");
  chk_pri_zero: assert property (o_pri_bus == CFGAR_PRI_BUS)
    else $error("primary bus number not zero");
  chk_cfg_complete: assert property (waiting && sel_ack |=> o_io_ack && o_io_ready &&
                                     o_io_rdata == $past(sel_rdata))
    else $error("target answer not returned to host");
  chk_reg_field: assert property (waiting && o_down.kind != CFGAR_CYC_IO |->
                                  o_down.addr[CFGAR_REG_HI:CFGAR_REG_LO] ==
                                  addr_port_reg[CFGAR_REG_HI:CFGAR_REG_LO])
    else $error("register number not carried to cycle");

endmodule : cfgar_router

// file: verif/cfgar_tgt_model.sv
module cfgar_tgt_model
  import cfgar_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [3:0] i_dly,
  input  wire cfgar_req_t i_down,
  input  wire logic       i_int_valid,
  input  wire logic       i_hub_valid,
  input  wire logic       i_gfx_valid,
  output logic            o_int_ack,
  output logic            o_hub_ack,
  output logic            o_gfx_ack,
  output logic [31:0]     o_int_rdata,
  output logic [31:0]     o_hub_rdata,
  output logic [31:0]     o_gfx_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_reg;
  logic       any_ack;
  // Data is valid only in the ack cycle; otherwise the inverse is shown
  assign any_ack     = o_int_ack | o_hub_ack | o_gfx_ack;
  assign o_int_rdata = (32'h1100_0000 ^ i_down.addr) ^ {32{~o_int_ack}};
  assign o_hub_rdata = (32'h2200_0000 ^ i_down.addr) ^ {32{~o_hub_ack}};
  assign o_gfx_rdata = (32'h3300_0000 ^ i_down.addr) ^ {32{~o_gfx_ack}};
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg   <= 4'h0;
      o_int_ack <= 1'b0;
      o_hub_ack <= 1'b0;
      o_gfx_ack <= 1'b0;
    end else if (any_ack) begin
      cnt_reg   <= 4'h0;
      o_int_ack <= 1'b0;
      o_hub_ack <= 1'b0;
      o_gfx_ack <= 1'b0;
    end else if (cnt_reg == i_dly) begin
      o_int_ack <= i_int_valid;
      // Hub side answers any bus number; its own bridge ranges pick the bus behind it
      o_hub_ack <= i_hub_valid;
      o_gfx_ack <= i_gfx_valid;
    end else if (i_int_valid | i_hub_valid | i_gfx_valid) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule : cfgar_tgt_model

// file: verif/cfgar_router_test.sv
module cfgar_router_test
  import cfgar_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [31:0]  cadr;
    logic         en0;
    logic         en1;
    logic [7:0]   sec;
    logic [7:0]   sub;
    cfgar_route_t rt;
    cfgar_cyc_t   kind;
    logic [1:0]   tc;
  } cfgar_row_t;
  logic i_clk, i_rst, i_io_valid, o_io_ready, o_io_ack, i_dev0_en, i_dev1_en;
  logic o_int_valid, o_hub_valid, o_gfx_valid, int_ack, hub_ack, gfx_ack;
  logic [31:0] o_io_rdata, int_rd, hub_rd, gfx_rd, rd, ea;
  logic [7:0] i_sec_bus, i_sub_bus, o_pri_bus;
  logic [3:0] dly;
  cfgar_io_t i_io;
  cfgar_req_t o_down, seen_down;
  cfgar_route_t seen_rt;
  cfgar_row_t rows [10];
  int n_mismatch, n_tests, n_cyc;
  cfgar_router i_cfgar_router (.i_clk(i_clk), .i_rst(i_rst), .i_io_valid(i_io_valid), .i_io(i_io),
    .o_io_ready(o_io_ready), .o_io_ack(o_io_ack), .o_io_rdata(o_io_rdata), .i_dev0_en(i_dev0_en),
    .i_dev1_en(i_dev1_en), .i_sec_bus(i_sec_bus), .i_sub_bus(i_sub_bus), .o_pri_bus(o_pri_bus),
    .o_down(o_down), .o_int_valid(o_int_valid), .i_int_ack(int_ack), .i_int_rdata(int_rd),
    .o_hub_valid(o_hub_valid), .i_hub_ack(hub_ack), .i_hub_rdata(hub_rd), .o_gfx_valid(o_gfx_valid),
    .i_gfx_ack(gfx_ack), .i_gfx_rdata(gfx_rd));
  cfgar_tgt_model i_cfgar_tgt_model (.i_clk(i_clk), .i_rst(i_rst), .i_dly(dly), .i_down(o_down),
    .i_int_valid(o_int_valid), .i_hub_valid(o_hub_valid), .i_gfx_valid(o_gfx_valid),
    .o_int_ack(int_ack), .o_hub_ack(hub_ack), .o_gfx_ack(gfx_ack), .o_int_rdata(int_rd),
    .o_hub_rdata(hub_rd), .o_gfx_rdata(gfx_rd));
  // ==========================================================================
  // Clock, timeout and helpers
  // ==========================================================================
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    n_cyc++;
    if (n_cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  // Records which target was asked and with what
  always @(negedge i_clk) begin
    if (o_int_valid) seen_rt = CFGAR_RT_INT;
    if (o_hub_valid) seen_rt = CFGAR_RT_HUB;
    if (o_gfx_valid) seen_rt = CFGAR_RT_GFX;
    if (o_int_valid | o_hub_valid | o_gfx_valid) seen_down = o_down;
  end
  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic io(input logic wr, input logic [15:0] a, input logic [3:0] be, input logic [31:0] wd);
    int k;
    k = 0;
    seen_rt = CFGAR_RT_LOCAL;
    seen_down = '0;
    i_io = '{wr, a, be, wd};
    i_io_valid = 1'b1;
    @(negedge i_clk);
    i_io_valid = 1'b0;
    while (o_io_ack !== 1'b1 && k < 60) begin
      @(negedge i_clk);
      k++;
    end
    check(k < 60, 1'b1);
    rd = o_io_rdata;
    @(negedge i_clk);
  endtask : io
  function automatic logic [31:0] mk(logic [7:0] b, logic [4:0] d, logic [2:0] f, logic [5:0] r);
    return {1'b1, 7'h00, b, d, f, r, 2'b00};
  endfunction : mk
  function automatic logic [31:0] base(cfgar_route_t r);
    return (r == CFGAR_RT_INT) ? 32'h1100_0000 : (r == CFGAR_RT_HUB) ? 32'h2200_0000 : 32'h3300_0000;
  endfunction : base
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    {i_rst, i_io_valid, i_io, i_dev0_en, i_dev1_en, dly} = {1'b1, 1'b0, 53'h0, 2'b00, 4'h0};
    {i_sec_bus, i_sub_bus} = 16'h0305;
    rows[0] = '{mk(8'h00, 5'h00, 3'h0, 6'h00), 1'b1, 1'b1, 8'h03, 8'h05, CFGAR_RT_INT, CFGAR_CYC_CFG0, 2'h0};
    rows[1] = '{mk(8'h00, 5'h01, 3'h0, 6'h06), 1'b1, 1'b1, 8'h03, 8'h05, CFGAR_RT_INT, CFGAR_CYC_CFG0, 2'h0};
    rows[2] = '{mk(8'h00, 5'h00, 3'h0, 6'h01), 1'b0, 1'b1, 8'h03, 8'h05, CFGAR_RT_HUB, CFGAR_CYC_CFG0, 2'h0};
    rows[3] = '{mk(8'h00, 5'h01, 3'h2, 6'h01), 1'b1, 1'b0, 8'h03, 8'h05, CFGAR_RT_HUB, CFGAR_CYC_CFG0, 2'h0};
    rows[4] = '{mk(8'h00, 5'h05, 3'h1, 6'h02), 1'b1, 1'b1, 8'h00, 8'h05, CFGAR_RT_HUB, CFGAR_CYC_CFG0, 2'h0};
    rows[5] = '{mk(8'h02, 5'h03, 3'h0, 6'h00), 1'b1, 1'b1, 8'h03, 8'h05, CFGAR_RT_HUB, CFGAR_CYC_CFG1, 2'h1};
    rows[6] = '{mk(8'h06, 5'h1F, 3'h0, 6'h00), 1'b1, 1'b1, 8'h03, 8'h05, CFGAR_RT_HUB, CFGAR_CYC_CFG1, 2'h1};
    rows[7] = '{mk(8'h03, 5'h00, 3'h0, 6'h3F), 1'b1, 1'b1, 8'h03, 8'h05, CFGAR_RT_GFX, CFGAR_CYC_CFG0, 2'h0};
    rows[8] = '{mk(8'h05, 5'h02, 3'h7, 6'h3F), 1'b1, 1'b1, 8'h03, 8'h05, CFGAR_RT_GFX, CFGAR_CYC_CFG1, 2'h1};
    rows[9] = '{mk(8'h04, 5'h00, 3'h0, 6'h00) & 32'h7FFF_FFFF, 1'b1, 1'b1, 8'h03, 8'h05, CFGAR_RT_HUB,
                CFGAR_CYC_IO, 2'h0};
    repeat (4) @(negedge i_clk);
    i_rst = 1'b0;
    check(o_pri_bus, CFGAR_PRI_BUS);
    check(o_io_ready, 1'b1);
    io(1'b0, CFGAR_ADDR_PORT_OFS, CFGAR_BE_DWORD, 32'h0);
    check(rd, CFGAR_ADDR_PORT_RST);
    $display("reset test done");
    foreach (rows[i]) begin
      {i_dev0_en, i_dev1_en, i_sec_bus, i_sub_bus} = {rows[i].en0, rows[i].en1, rows[i].sec, rows[i].sub};
      io(1'b1, CFGAR_ADDR_PORT_OFS, CFGAR_BE_DWORD, rows[i].cadr);
      io(1'b0, CFGAR_DATA_PORT_OFS + 16'h0002, CFGAR_BE_DWORD, 32'h0);
      ea = (rows[i].kind == CFGAR_CYC_IO) ? 32'h0000_0CFE : {rows[i].cadr[31:2], rows[i].tc};
      check(seen_rt, rows[i].rt);
      check(seen_down.kind, rows[i].kind);
      check(seen_down.addr, ea);
      check(rd, base(rows[i].rt) ^ ea);
      $display("row %0d done", i);
    end
    io(1'b1, CFGAR_ADDR_PORT_OFS + 16'h0003, CFGAR_BE_DWORD, 32'hFFFF_FFFF);
    io(1'b0, CFGAR_ADDR_PORT_OFS, CFGAR_BE_DWORD, 32'h0);
    check(rd, 32'h80FF_FFFC);
    check(seen_rt, CFGAR_RT_LOCAL);
    io(1'b1, CFGAR_ADDR_PORT_OFS, 4'h3, 32'h0);
    check({seen_rt, seen_down.kind, seen_down.be}, {CFGAR_RT_HUB, CFGAR_CYC_IO, 4'h3});
    io(1'b0, CFGAR_ADDR_PORT_OFS, 4'h1, 32'h0);
    check({seen_rt, seen_down.kind, seen_down.wr}, {CFGAR_RT_HUB, CFGAR_CYC_IO, 1'b0});
    io(1'b0, CFGAR_ADDR_PORT_OFS, CFGAR_BE_DWORD, 32'h0);
    check(rd, 32'h80FF_FFFC);
    $display("address port test done");
    {i_sec_bus, i_sub_bus, dly} = {8'h10, 8'hFF, 4'h6};
    io(1'b1, CFGAR_DATA_PORT_OFS, 4'h6, 32'hA5A5_5A5A);
    check({seen_rt, seen_down.kind, seen_down.wr}, {CFGAR_RT_GFX, CFGAR_CYC_CFG1, 1'b1});
    check({seen_down.be, seen_down.wdata, seen_down.addr}, {4'h6, 32'hA5A5_5A5A, 32'h80FF_FFFD});
    io(1'b1, 16'h0080, CFGAR_BE_DWORD, 32'h1234_5678);
    check({seen_rt, seen_down.kind, seen_down.addr}, {CFGAR_RT_HUB, CFGAR_CYC_IO, 32'h0000_0080});
    $display("data write test done");
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    io(1'b0, CFGAR_DATA_PORT_OFS, CFGAR_BE_DWORD, 32'h0);
    check({seen_rt, seen_down.kind}, {CFGAR_RT_HUB, CFGAR_CYC_IO});
    check(rd, base(CFGAR_RT_HUB) ^ 32'h0000_0CFC);
    $display("second reset test done");
    complete_run();
  end
endmodule : cfgar_router_test
